// ### hdl/brf_pkg.sv
// brf_pkg: constants, field positions and carrier types for the banked register file
// assumes the core decodes instructions and drives architectural indices and write strobes
package brf_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int unsigned WORD_W    = 32;  // register width
   localparam int unsigned LOW_N     = 8;   // low registers per bank
   localparam int unsigned HIGH_N    = 8;   // unbanked high registers
   localparam int unsigned GEN_N     = 16;  // architectural general registers
   localparam int unsigned FP_N      = 16;  // fp registers per bank
   localparam int unsigned QUAD_N    = 4;   // vectors / matrix columns
   localparam int unsigned PAIR_N    = 8;   // pair views
   localparam int unsigned IDX_W     = 4;   // register index width
   localparam int unsigned LOW_IDX_W = 3;   // low register index width

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int unsigned FP_BANK_SWAP_POS = 21;  // position in fp_status_control
   localparam logic        MODE_RESET       = 1'h1; // privileged after reset
   localparam logic        BANK_SEL_RESET   = 1'h1; // low bank one after reset
   localparam logic        BANK_SEL_EXC     = 1'h1; // value forced on exception entry
   localparam logic [3:0]  LOW_LIMIT        = 4'h8; // first high register index

   // ****************************************
   // carrier types
   // ****************************************
   typedef logic [WORD_W-1:0] brf_word_t;

   // one write port request
   typedef struct packed {
      logic             en;    // write strobe
      logic [IDX_W-1:0] idx;   // architectural index
      brf_word_t        data;  // write value
   } brf_wr_t;

   // control load/store access to the bank not mapped as r0..r7
   typedef struct packed {
      logic                 en;    // write strobe
      logic [LOW_IDX_W-1:0] idx;   // hidden low register
      brf_word_t            data;  // write value
   } brf_alt_wr_t;

   // fp write: extended selects the opposite bank
   typedef struct packed {
      logic             en;
      logic             extended;
      logic [IDX_W-1:0] idx;
      brf_word_t        data;
   } brf_fp_wr_t;

   // status bits owned here
   typedef struct packed {
      logic mode;      // privilege_mode_bit
      logic bank_sel;  // privileged_bank_select
   } brf_status_t;
endpackage : brf_pkg

// ### hdl/brf_banked_regfile.sv
// brf_banked_regfile: banked general and floating-point register storage with views
// assumes one write per port per cycle and that decode blocks privileged accesses in user mode
`timescale 1ns/1ps
module brf_banked_regfile (
   input  wire logic                                 core_clk,
   input  wire logic                                 resetn,
   input  wire logic                                 exc_take,
   input  wire logic                                 status_wr_en,
   input  wire brf_pkg::brf_status_t                 status_wr,
   input  wire logic                                 fpsc_wr_en,
   input  wire brf_pkg::brf_word_t                   fpsc_wr,
   input  wire brf_pkg::brf_wr_t                     gen_wr,
   input  wire brf_pkg::brf_alt_wr_t                 alt_wr,
   input  wire brf_pkg::brf_fp_wr_t                  fp_wr,
   input  wire logic [brf_pkg::IDX_W-1:0]            gen_rd_idx,
   input  wire logic [brf_pkg::LOW_IDX_W-1:0]        alt_rd_idx,
   input  wire logic [brf_pkg::IDX_W-1:0]            fp_rd_idx,
   output brf_pkg::brf_status_t                      status_q,
   output logic                                      fp_bank_swap_q,
   output brf_pkg::brf_word_t                        gen_rd_q,
   output brf_pkg::brf_word_t                        alt_rd_q,
   output brf_pkg::brf_word_t                        fp_single_q,
   output brf_pkg::brf_word_t                        fp_extended_q,
   output logic [2*brf_pkg::WORD_W-1:0]              fp_pair_q,
   output logic [2*brf_pkg::WORD_W-1:0]              fp_ext_pair_q,
   output logic [4*brf_pkg::WORD_W-1:0]              fp_quad_q,
   output logic [16*brf_pkg::WORD_W-1:0]             fp_ext_matrix_q
);
   // ****************************************
   // helpers
   // ****************************************
   // true when low bank one serves r0..r7 in the current status
   function automatic logic use_bank_one(input brf_pkg::brf_status_t st);
      use_bank_one = st.mode & st.bank_sel;
   endfunction : use_bank_one

   // true when an architectural index names a banked low register
   function automatic logic is_low(input logic [brf_pkg::IDX_W-1:0] idx);
      is_low = (idx < brf_pkg::LOW_LIMIT);
   endfunction : is_low

   // ****************************************
   // status bits
   // ****************************************
   brf_pkg::brf_status_t status_d;      // next status
   logic                 fp_bank_swap_d;  // next swap bit

   // exception entry beats a software status write in the same cycle
   always_comb begin
      status_d       = status_q;
      fp_bank_swap_d = fp_bank_swap_q;
      if (status_wr_en) begin
         status_d = status_wr;
      end
      if (exc_take) begin
         status_d.mode     = brf_pkg::MODE_RESET;    // handler runs privileged
         status_d.bank_sel = brf_pkg::BANK_SEL_EXC;
      end
      if (fpsc_wr_en) begin
         fp_bank_swap_d = fpsc_wr[brf_pkg::FP_BANK_SWAP_POS];
      end
   end

   // status registers hold a defined value from reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_q.mode     <= brf_pkg::MODE_RESET;
         status_q.bank_sel <= brf_pkg::BANK_SEL_RESET;
         fp_bank_swap_q    <= 1'h0;
      end else begin
         status_q       <= status_d;
         fp_bank_swap_q <= fp_bank_swap_d;
      end
   end

   // ****************************************
   // general register storage
   // ****************************************
   // no reset on storage: contents are undefined after reset, saves area
   brf_pkg::brf_word_t bank0_q [brf_pkg::LOW_N];   // low_bank_zero
   brf_pkg::brf_word_t bank1_q [brf_pkg::LOW_N];   // low_bank_one
   brf_pkg::brf_word_t high_q  [brf_pkg::HIGH_N];  // shared r8..r15
   brf_pkg::brf_word_t bank0_d [brf_pkg::LOW_N];
   brf_pkg::brf_word_t bank1_d [brf_pkg::LOW_N];
   brf_pkg::brf_word_t high_d  [brf_pkg::HIGH_N];
   logic               sel_one;   // current mapping of r0..r7
   logic [brf_pkg::LOW_IDX_W-1:0] gen_low_idx;  // low part of write index

   assign sel_one     = use_bank_one(status_q);
   assign gen_low_idx = gen_wr.idx[brf_pkg::LOW_IDX_W-1:0];

   // next values: mapped port writes the active bank, alternate port the hidden one
   always_comb begin
      bank0_d = bank0_q;
      bank1_d = bank1_q;
      high_d  = high_q;
      // alternate port first, so the normal port wins on a collision
      // user mode must not reach low bank one at all, so the port is gated here too
      if (alt_wr.en && status_q.mode) begin
         if (sel_one) begin
            bank0_d[alt_wr.idx] = alt_wr.data;
         end else begin
            bank1_d[alt_wr.idx] = alt_wr.data;
         end
      end
      if (gen_wr.en) begin
         if (!is_low(gen_wr.idx)) begin
            high_d[gen_low_idx] = gen_wr.data;
         end else if (sel_one) begin
            bank1_d[gen_low_idx] = gen_wr.data;
         end else begin
            bank0_d[gen_low_idx] = gen_wr.data;
         end
      end
   end

   // storage only registers next values
   always_ff @(posedge core_clk) begin
      bank0_q <= bank0_d;
      bank1_q <= bank1_d;
      high_q  <= high_d;
   end

   // ****************************************
   // general read ports
   // ****************************************
   brf_pkg::brf_word_t gen_rd_d;  // sixteen-way mapped read
   brf_pkg::brf_word_t alt_rd_d;  // hidden bank read

   // one read mux picks exactly sixteen of twenty-four registers
   always_comb begin
      if (!is_low(gen_rd_idx)) begin
         gen_rd_d = high_q[gen_rd_idx[brf_pkg::LOW_IDX_W-1:0]];
      end else if (sel_one) begin
         gen_rd_d = bank1_q[gen_rd_idx[brf_pkg::LOW_IDX_W-1:0]];
      end else begin
         gen_rd_d = bank0_q[gen_rd_idx[brf_pkg::LOW_IDX_W-1:0]];
      end
      // the alternate port shows the bank not mapped to r0..r7, forced to zero below in user mode
      alt_rd_d = sel_one ? bank0_q[alt_rd_idx] : bank1_q[alt_rd_idx];
      // user mode hides the second low bank from every port
      if (!status_q.mode) begin
         alt_rd_d = '0;
      end
   end

   // ****************************************
   // floating-point storage
   // ****************************************
   brf_pkg::brf_word_t fpb0_q [brf_pkg::FP_N];  // fp bank 0
   brf_pkg::brf_word_t fpb1_q [brf_pkg::FP_N];  // fp bank 1
   brf_pkg::brf_word_t fpb0_d [brf_pkg::FP_N];
   brf_pkg::brf_word_t fpb1_d [brf_pkg::FP_N];
   logic               fp_to_one;  // target bank of the fp write

   // single view in bank = swap, extended view in the other bank
   always_comb begin
      fpb0_d    = fpb0_q;
      fpb1_d    = fpb1_q;
      fp_to_one = fp_bank_swap_q ^ fp_wr.extended;
      if (fp_wr.en) begin
         if (fp_to_one) begin
            fpb1_d[fp_wr.idx] = fp_wr.data;
         end else begin
            fpb0_d[fp_wr.idx] = fp_wr.data;
         end
      end
   end

   // fp storage, undefined after reset
   always_ff @(posedge core_clk) begin
      fpb0_q <= fpb0_d;
      fpb1_q <= fpb1_d;
   end

   // ****************************************
   // floating-point views
   // ****************************************
   brf_pkg::brf_word_t fr_v [brf_pkg::FP_N];  // single view
   brf_pkg::brf_word_t xf_v [brf_pkg::FP_N];  // extended view
   logic [16*brf_pkg::WORD_W-1:0] mtx_d;      // column-major matrix

   // view wiring per register index
   for (genvar i = 0; i < brf_pkg::FP_N; i++) begin : g_view
      assign fr_v[i] = fp_bank_swap_q ? fpb1_q[i] : fpb0_q[i];
      assign xf_v[i] = fp_bank_swap_q ? fpb0_q[i] : fpb1_q[i];
      // element i = column i/4, row i%4; lowest register in top word
      assign mtx_d[(16-i)*brf_pkg::WORD_W-1 -: brf_pkg::WORD_W] = xf_v[i];
   end

   logic [brf_pkg::IDX_W-1:0] pair_base;  // even index of pair
   logic [brf_pkg::IDX_W-1:0] quad_base;  // index of vector start
   logic [2*brf_pkg::WORD_W-1:0] pair_d;
   logic [2*brf_pkg::WORD_W-1:0] xpair_d;
   logic [4*brf_pkg::WORD_W-1:0] quad_d;

   // odd low bits of the index are ignored: views only start on aligned registers
   always_comb begin
      pair_base = {fp_rd_idx[brf_pkg::IDX_W-1:1], 1'h0};
      quad_base = {fp_rd_idx[brf_pkg::IDX_W-1:2], 2'h0};
      pair_d  = {fr_v[pair_base], fr_v[pair_base | 4'h1]};
      xpair_d = {xf_v[pair_base], xf_v[pair_base | 4'h1]};
      quad_d  = {fr_v[quad_base], fr_v[quad_base | 4'h1],
                 fr_v[quad_base | 4'h2], fr_v[quad_base | 4'h3]};
   end

   // ****************************************
   // registered read outputs
   // ****************************************
   // one cycle of read latency keeps every output on a flip-flop
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gen_rd_q        <= '0;
         alt_rd_q        <= '0;
         fp_single_q     <= '0;
         fp_extended_q   <= '0;
         fp_pair_q       <= '0;
         fp_ext_pair_q   <= '0;
         fp_quad_q       <= '0;
         fp_ext_matrix_q <= '0;
      end else begin
         gen_rd_q        <= gen_rd_d;
         alt_rd_q        <= alt_rd_d;
         fp_single_q     <= fr_v[fp_rd_idx];
         fp_extended_q   <= xf_v[fp_rd_idx];
         fp_pair_q       <= pair_d;
         fp_ext_pair_q   <= xpair_d;
         fp_quad_q       <= quad_d;
         fp_ext_matrix_q <= mtx_d;
      end
   end
endmodule : brf_banked_regfile

// ### verification/brf_checker.sv
// brf_checker: port-level checks for the banked register file
// assumes the bind below attaches it to brf_banked_regfile
`timescale 1ns/1ps
module brf_checker (
   input wire logic                       core_clk,
   input wire logic                       resetn,
   input wire logic                       exc_take,
   input wire logic                       status_wr_en,
   input wire brf_pkg::brf_status_t       status_wr,
   input wire logic                       fpsc_wr_en,
   input wire brf_pkg::brf_word_t         fpsc_wr,
   input wire logic [3:0]                 fp_rd_idx,
   input wire brf_pkg::brf_status_t       status_q,
   input wire logic                       fp_bank_swap_q,
   input wire brf_pkg::brf_word_t         fp_single_q,
   input wire brf_pkg::brf_word_t         fp_extended_q,
   input wire logic [63:0]                fp_pair_q,
   input wire logic [63:0]                fp_ext_pair_q,
   input wire logic [127:0]               fp_quad_q,
   input wire logic [511:0]               fp_ext_matrix_q
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // ****************************************
   // status bits
   // ****************************************
   a_exc_sets_bank: assert property (exc_take |=> status_q == 2'h3)
      else $error("exception entry did not set mode and bank select");
   a_status_load: assert property (status_wr_en && !exc_take |=> status_q == $past(status_wr))
      else $error("status write not taken");
   a_status_hold: assert property (!status_wr_en && !exc_take |=> $stable(status_q))
      else $error("status changed without cause");
   a_swap_load: assert property (fpsc_wr_en |=> fp_bank_swap_q == $past(fpsc_wr[21]))
      else $error("bank swap not loaded from bit 21");
   a_swap_hold: assert property (!fpsc_wr_en |=> $stable(fp_bank_swap_q))
      else $error("bank swap changed without write");
   // ****************************************
   // views agree with the single registers
   // ****************************************
   a_pair_high: assert property (!fp_rd_idx[0] |=> fp_pair_q[63:32] === fp_single_q)
      else $error("pair view high word mismatch");
   a_xpair_low: assert property (fp_rd_idx[0] |=> fp_ext_pair_q[31:0] === fp_extended_q)
      else $error("extended pair low word mismatch");
   a_quad_word: assert property (1'b1 |=>
      fp_quad_q[32*(3-$past(fp_rd_idx[1:0])) +: 32] === fp_single_q)
      else $error("quad view word mismatch");
   a_matrix_col: assert property (1'b1 |=>
      fp_ext_matrix_q[32*(15-$past(fp_rd_idx)) +: 32] === fp_extended_q)
      else $error("matrix element mismatch");
   c_exc: cover property (exc_take);
   c_swap: cover property (fpsc_wr_en && fpsc_wr[21]);
   c_user: cover property (status_wr_en && !status_wr.mode);
endmodule : brf_checker

bind brf_banked_regfile brf_checker i_chk (.core_clk(core_clk), .resetn(resetn),
   .exc_take(exc_take), .status_wr_en(status_wr_en), .status_wr(status_wr),
   .fpsc_wr_en(fpsc_wr_en), .fpsc_wr(fpsc_wr), .fp_rd_idx(fp_rd_idx), .status_q(status_q),
   .fp_bank_swap_q(fp_bank_swap_q), .fp_single_q(fp_single_q),
   .fp_extended_q(fp_extended_q), .fp_pair_q(fp_pair_q), .fp_ext_pair_q(fp_ext_pair_q),
   .fp_quad_q(fp_quad_q), .fp_ext_matrix_q(fp_ext_matrix_q));

// ### verification/tb_banked_register_file_mapping.sv
// tb_banked_register_file_mapping: directed bench for the banked register file
// assumes inputs are driven on the falling edge and read one cycle later
`timescale 1ns/1ps
module tb_banked_register_file_mapping;
   logic                  core_clk = 1'b0;
   logic                  resetn = 1'b0;
   logic                  exc_take = 1'b0;
   logic                  status_wr_en = 1'b0;
   brf_pkg::brf_status_t  status_wr = '0;
   logic                  fpsc_wr_en = 1'b0;
   brf_pkg::brf_word_t    fpsc_wr = '0;
   brf_pkg::brf_wr_t      gen_wr = '0;
   brf_pkg::brf_alt_wr_t  alt_wr = '0;
   brf_pkg::brf_fp_wr_t   fp_wr = '0;
   logic [3:0]            gen_rd_idx = '0;
   logic [2:0]            alt_rd_idx = '0;
   logic [3:0]            fp_rd_idx = '0;
   brf_pkg::brf_status_t  status_q;
   logic                  fp_bank_swap_q;
   brf_pkg::brf_word_t    gen_rd_q, alt_rd_q, fp_single_q, fp_extended_q;
   logic [63:0]           fp_pair_q, fp_ext_pair_q;
   logic [127:0]          fp_quad_q;
   logic [511:0]          fp_ext_matrix_q;
   int                    fails = 0;
   int                    check_count = 0;
   int                    cyc = 0;
   initial forever #12.5 core_clk = ~core_clk;  // 40 MHz
   brf_banked_regfile i_dut (.core_clk(core_clk), .resetn(resetn), .exc_take(exc_take),
      .status_wr_en(status_wr_en), .status_wr(status_wr), .fpsc_wr_en(fpsc_wr_en),
      .fpsc_wr(fpsc_wr), .gen_wr(gen_wr), .alt_wr(alt_wr), .fp_wr(fp_wr),
      .gen_rd_idx(gen_rd_idx), .alt_rd_idx(alt_rd_idx), .fp_rd_idx(fp_rd_idx),
      .status_q(status_q), .fp_bank_swap_q(fp_bank_swap_q), .gen_rd_q(gen_rd_q),
      .alt_rd_q(alt_rd_q), .fp_single_q(fp_single_q), .fp_extended_q(fp_extended_q),
      .fp_pair_q(fp_pair_q), .fp_ext_pair_q(fp_ext_pair_q), .fp_quad_q(fp_quad_q),
      .fp_ext_matrix_q(fp_ext_matrix_q));
   // ****************************************
   // helpers
   // ****************************************
   task automatic nx;
      @(negedge core_clk);
   endtask : nx
   task automatic chk(input string nm, input logic [511:0] s, input logic [511:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic st(input logic [1:0] v);
      status_wr = v;
      status_wr_en = 1'b1;
      nx;
      status_wr_en = 1'b0;
   endtask : st
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // hang guard, the whole run needs under a hundred cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         stop_test;
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_gen;
      gen_wr = {1'b1, 4'h3, 32'haaaa0003};  // reset leaves bank one mapped
      nx;
      gen_wr = {1'b1, 4'h9, 32'h99990009};
      nx;
      gen_wr.en = 1'b0;
      st(2'h2);
      gen_wr = {1'b1, 4'h3, 32'hbbbb0003};
      alt_wr = {1'b1, 3'h5, 32'hcccc0005};  // hidden bank is bank one here
      nx;
      gen_wr.en = 1'b0;
      alt_wr.en = 1'b0;
      gen_rd_idx = 4'h3;
      alt_rd_idx = 3'h3;
      nx;
      chk("r3 bank0", gen_rd_q, 32'hbbbb0003);
      chk("alt r3 bank1", alt_rd_q, 32'haaaa0003);
      st(2'h1);
      alt_wr = {1'b1, 3'h3, 32'hdead0003};  // must be blocked in user mode
      nx;
      alt_wr.en = 1'b0;
      chk("user r3", gen_rd_q, 32'hbbbb0003);
      chk("user alt", alt_rd_q, 32'h0);
      gen_rd_idx = 4'h9;
      nx;
      chk("user r9", gen_rd_q, 32'h99990009);
      exc_take = 1'b1;
      nx;
      exc_take = 1'b0;
      chk("exc status", status_q, 2'h3);
      gen_rd_idx = 4'h5;
      nx;
      chk("r5 bank1", gen_rd_q, 32'hcccc0005);
      gen_rd_idx = 4'h3;
      nx;
      chk("exc r3", gen_rd_q, 32'haaaa0003);
      chk("alt r3 bank0", alt_rd_q, 32'hbbbb0003);
      $display("test gen done");
   endtask : t_gen
   task automatic fp_views(input logic [31:0] fb, input logic [31:0] xb);
      logic [511:0] m;
      for (int i = 0; i < 16; i++) begin
         fp_rd_idx = i[3:0];
         nx;
         m[32*(15-i) +: 32] = xb + i;
         chk("single", fp_single_q, fb + i);
         chk("extended", fp_extended_q, xb + i);
         if (i % 2 == 0) begin
            chk("pair", fp_pair_q, {fb + i, fb + i + 1});
            chk("xpair", fp_ext_pair_q, {xb + i, xb + i + 1});
         end
         if (i % 4 == 0) begin
            chk("quad", fp_quad_q, {fb + i, fb + i + 1, fb + i + 2, fb + i + 3});
         end
      end
      chk("matrix", fp_ext_matrix_q, m);
   endtask : fp_views
   task automatic t_fp;
      for (int i = 0; i < 16; i++) begin
         fp_wr = {1'b1, 1'b0, i[3:0], 32'h10000000 + i};
         nx;
         fp_wr = {1'b1, 1'b1, i[3:0], 32'h20000000 + i};
         nx;
      end
      fp_wr.en = 1'b0;
      fp_views(32'h10000000, 32'h20000000);
      fpsc_wr = 32'h00200000;
      fpsc_wr_en = 1'b1;
      nx;
      fpsc_wr_en = 1'b0;
      chk("swap set", fp_bank_swap_q, 1'b1);
      fp_views(32'h20000000, 32'h10000000);
      fpsc_wr = 32'hffdfffff;  // every bit but the swap bit
      fpsc_wr_en = 1'b1;
      nx;
      fpsc_wr_en = 1'b0;
      chk("swap clear", fp_bank_swap_q, 1'b0);
      $display("test fp done");
   endtask : t_fp
   task automatic t_reset;
      st(2'h0);
      resetn = 1'b0;
      nx;
      chk("reset status", status_q, 2'h3);
      resetn = 1'b1;
      nx;
      chk("after reset", status_q, 2'h3);
      $display("test reset done");
   endtask : t_reset
   initial begin
      nx;
      nx;
      resetn = 1'b1;
      chk("init status", status_q, 2'h3);
      chk("init swap", fp_bank_swap_q, 1'b0);
      t_gen;
      t_fp;
      t_reset;
      stop_test;
   end
endmodule : tb_banked_register_file_mapping
